// ---- logic/odt_pkg.sv ----
// Purpose: Shared constants and types of the termination selector
// Assumes: 32-bit AHB-Lite register slave, one clock
// Notes:   All offsets are byte addresses
package odt_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_NOM  = 3'h0;
    localparam logic [2:0] IDX_WR   = 3'h1;
    localparam logic [2:0] IDX_PARK = 3'h2;
    localparam logic [2:0] IDX_LAT  = 3'h3;
    localparam logic [2:0] IDX_STAT = 3'h4;
    localparam logic [31:0] OFF_NOM  = 32'h0000_0000;
    localparam logic [31:0] OFF_WR   = 32'h0000_0004;
    localparam logic [31:0] OFF_PARK = 32'h0000_0008;
    localparam logic [31:0] OFF_LAT  = 32'h0000_000c;
    localparam logic [31:0] OFF_STAT = 32'h0000_0010;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_CODE     = 0;
    localparam int POS_TDQS_EN  = 3;
    localparam int POS_X16      = 4;
    localparam int POS_WR_START = 8;
    localparam int POS_WR_LEN   = 16;
    localparam int POS_RL       = 0;
    localparam int POS_PIN_LAT  = 8;
    localparam int POS_PRE2     = 16;
    localparam int POS_CRC      = 17;
    localparam int POS_BC4      = 18;
    localparam int POS_ST_SEL   = 0;
    localparam int POS_ST_CODE  = 4;
    localparam int POS_ST_RX    = 8;
    localparam int POS_ST_SREF  = 9;
    localparam int POS_ST_RDOFF = 10;

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] RST_CODE     = 3'h0;
    localparam logic [5:0] RST_WR_START = 6'h07;
    localparam logic [5:0] RST_WR_LEN   = 6'h06;
    localparam logic [5:0] RST_RL       = 6'h0b;
    localparam logic [5:0] RST_PIN_LAT  = 6'h09;
    localparam logic [6:0] PRE1_LEAD    = 7'h02;
    localparam logic [6:0] PRE2_LEAD    = 7'h03;
    localparam logic [6:0] HALF_BL8     = 7'h04;
    localparam logic [6:0] HALF_BC4     = 7'h02;
    localparam logic [6:0] CRC_EXTRA    = 7'h01;
    localparam logic [6:0] DLY_PIPE     = 7'h02;
    localparam int         DLY_DEPTH    = 64;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_NOM  = 4'b0100,
        ST_PARK = 4'b1000
    } odt_sel_t;

    typedef struct packed {
        logic sref;
        logic wr_cmd;
        logic rd_cmd;
        logic pin;
    } odt_cmd_t;

    typedef struct packed {
        odt_sel_t   sel;
        logic [2:0] code;
        logic       lo_lane;
        logic       hi_lane;
        logic       tdqs;
        logic       pin_rx_en;
    } odt_term_t;

    typedef struct packed {
        logic [DLY_DEPTH-1:0] sr;
        logic                 q;
    } odt_dly_t;

    typedef struct packed {
        logic [2:0]  nom;
        logic [2:0]  wr;
        logic [2:0]  park;
        logic        tdqs_en;
        logic        x16;
        logic [5:0]  wr_start;
        logic [5:0]  wr_len;
        logic [5:0]  rl;
        logic [5:0]  pin_lat;
        logic        pre2;
        logic        crc;
        logic        bc4;
        logic        ap_wr;
        logic        ap_ok;
        logic [2:0]  ap_idx;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic        rd_act;
        logic [6:0]  rd_cnt;
        logic        wr_act;
        logic [6:0]  wr_cnt;
        odt_term_t   term;
    } odt_state_t;

endpackage

// ---- logic/odt_dly.sv ----
// Purpose: Tapped delay line for the sampled termination pin
// Assumes: Tap changes only while the pin is idle
// Notes:   Output is registered, adding one cycle to the tap
`timescale 1ns/1ps
module odt_dly (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       d,
    input  wire logic [5:0] tap,
    output logic            q
);

    odt_pkg::odt_dly_t s_q;
    odt_pkg::odt_dly_t s_d;

    // ------------------------------------------------------------
    // Shift and tap
    // ------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        s_d.sr = {s_q.sr[odt_pkg::DLY_DEPTH-2:0], d};
        s_d.q  = s_q.sr[tap];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;

endmodule

// ---- logic/odt_ctrl.sv ----
// Purpose: Termination state selection for the data lanes
// Assumes: Commands are one-cycle pulses, synchronous to sys_clk
// Notes:   Mode fields live in AHB-Lite registers, zero wait
`timescale 1ns/1ps

// Contract
// - Terminate all data, strobe, mask lanes; TDQS only when enabled.
// - Wide part terminates both upper and lower byte lanes.
// - Self refresh forces termination off entirely.
// - Pin ignored when nominal field is zero or in self refresh.
// - Termination enabled by any non-zero field; field sets resistance.
// - Exactly four states: off, write, nominal, park.
// - Write termination for a window after WRITE, pin regardless.
// - Pin high turns on nominal termination unless field disabled.
// - Park is default when nominal is off, also during writes with write field zero.
// - Priority: disable, write, nominal, park.
// - READ forces off for a window regardless of other settings.
// - Pin receiver powered down when nominal field is zero.
// - Read disable starts RL-2 or RL-3 clocks after READ.
// - Read disable lasts BL/2 plus 2 or 3, plus 1 with CRC.
// - Pin latency is CWL+AL+PL minus 2 or 3.
module odt_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire odt_pkg::odt_cmd_t cmd,
    output odt_pkg::odt_term_t     term
);

    odt_pkg::odt_state_t s_q;
    odt_pkg::odt_state_t s_d;

    logic       pin_gated;
    logic       pin_late;
    logic [6:0] pin_lat_eff;
    logic [5:0] tap;

    // ------------------------------------------------------------
    // Pin receiver and latency line
    // ------------------------------------------------------------
    // Receiver off saves power and makes the pin a don't-care
    assign pin_gated = cmd.pin & s_q.term.pin_rx_en;

    always_comb begin
        if (s_q.pre2) begin
            pin_lat_eff = {1'b0, s_q.pin_lat} - odt_pkg::PRE2_LEAD;
        end else begin
            pin_lat_eff = {1'b0, s_q.pin_lat} - odt_pkg::PRE1_LEAD;
        end
        // Line plus output flop add two cycles; short values saturate
        if (pin_lat_eff[6] || pin_lat_eff < odt_pkg::DLY_PIPE) begin
            tap = 6'h00;
        end else begin
            tap = 6'(pin_lat_eff - odt_pkg::DLY_PIPE);
        end
    end

    odt_dly u_dly (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .d       (pin_gated),
        .tap     (tap),
        .q       (pin_late)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       ap_take;
    logic [2:0] idx;
    logic       mapped;
    logic [6:0] rd_start;
    logic [6:0] rd_len;
    logic [6:0] rd_end;
    logic [6:0] wr_end;
    logic       in_rd;
    logic       in_wr;
    logic       nom_on;
    logic       any_on;
    logic [31:0] rdv;

    always_comb begin
        s_d = s_q;
        rdv = 32'h0000_0000;

        // Bus address phase
        ap_take = hsel & htrans[1] & hready;
        idx     = haddr[4:2];
        mapped  = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0)
                  && (idx <= odt_pkg::IDX_STAT);

        // Bus data phase: apply the write stored last cycle
        if (s_q.ap_wr && s_q.ap_ok) begin
            case (s_q.ap_idx)
                odt_pkg::IDX_NOM: begin
                    s_d.nom     = hwdata[odt_pkg::POS_CODE +: 3];
                    s_d.tdqs_en = hwdata[odt_pkg::POS_TDQS_EN];
                    s_d.x16     = hwdata[odt_pkg::POS_X16];
                end
                odt_pkg::IDX_WR: begin
                    s_d.wr       = hwdata[odt_pkg::POS_CODE +: 3];
                    s_d.wr_start = hwdata[odt_pkg::POS_WR_START +: 6];
                    s_d.wr_len   = hwdata[odt_pkg::POS_WR_LEN +: 6];
                end
                odt_pkg::IDX_PARK: begin
                    s_d.park = hwdata[odt_pkg::POS_CODE +: 3];
                end
                odt_pkg::IDX_LAT: begin
                    s_d.rl      = hwdata[odt_pkg::POS_RL +: 6];
                    s_d.pin_lat = hwdata[odt_pkg::POS_PIN_LAT +: 6];
                    s_d.pre2    = hwdata[odt_pkg::POS_PRE2];
                    s_d.crc     = hwdata[odt_pkg::POS_CRC];
                    s_d.bc4     = hwdata[odt_pkg::POS_BC4];
                end
                default: begin
                end
            endcase
        end

        // Read disable window timing
        if (s_d.pre2) begin
            rd_start = {1'b0, s_d.rl} - odt_pkg::PRE2_LEAD;
            rd_len   = odt_pkg::PRE2_LEAD;
        end else begin
            rd_start = {1'b0, s_d.rl} - odt_pkg::PRE1_LEAD;
            rd_len   = odt_pkg::PRE1_LEAD;
        end
        if (rd_start[6]) begin
            rd_start = 7'h00;
        end
        rd_len = rd_len + (s_d.bc4 ? odt_pkg::HALF_BC4
                                   : odt_pkg::HALF_BL8);
        if (s_d.crc) begin
            rd_len = rd_len + odt_pkg::CRC_EXTRA;
        end
        rd_end = rd_start + rd_len;
        wr_end = {1'b0, s_d.wr_start} + {1'b0, s_d.wr_len};

        // Cycle counters since the last command; a new one restarts
        if (cmd.rd_cmd) begin
            s_d.rd_act = 1'b1;
            s_d.rd_cnt = 7'h00;
        end else if (s_q.rd_act) begin
            s_d.rd_cnt = s_q.rd_cnt + 7'h01;
            s_d.rd_act = (s_q.rd_cnt + 7'h01) < rd_end;
        end
        if (cmd.wr_cmd) begin
            s_d.wr_act = 1'b1;
            s_d.wr_cnt = 7'h00;
        end else if (s_q.wr_act) begin
            s_d.wr_cnt = s_q.wr_cnt + 7'h01;
            s_d.wr_act = (s_q.wr_cnt + 7'h01) < wr_end;
        end

        in_rd = s_d.rd_act && (s_d.rd_cnt >= rd_start)
                && (s_d.rd_cnt < rd_end);
        in_wr = s_d.wr_act && (s_d.wr_cnt >= {1'b0, s_d.wr_start})
                && (s_d.wr_cnt < wr_end);

        // Pin only counts with nominal enabled and out of self refresh
        nom_on = pin_late && (s_d.nom != 3'h0) && !cmd.sref;

        // Priority resolution into one of four states
        if (cmd.sref || in_rd) begin
            s_d.term.sel  = odt_pkg::ST_OFF;
            s_d.term.code = 3'h0;
        end else if (in_wr && s_d.wr != 3'h0) begin
            s_d.term.sel  = odt_pkg::ST_WR;
            s_d.term.code = s_d.wr;
        end else if (nom_on) begin
            s_d.term.sel  = odt_pkg::ST_NOM;
            s_d.term.code = s_d.nom;
        end else if (s_d.park != 3'h0) begin
            s_d.term.sel  = odt_pkg::ST_PARK;
            s_d.term.code = s_d.park;
        end else begin
            s_d.term.sel  = odt_pkg::ST_OFF;
            s_d.term.code = 3'h0;
        end

        // Lane enables follow the chosen state
        any_on          = (s_d.term.sel != odt_pkg::ST_OFF);
        s_d.term.lo_lane = any_on;
        s_d.term.hi_lane = any_on && s_d.x16;
        s_d.term.tdqs    = any_on && s_d.tdqs_en && !s_d.x16;
        s_d.term.pin_rx_en = (s_d.nom != 3'h0) && !cmd.sref;

        // Read data prepared in the address phase; config fields from next values, status sel, code and receiver from current ones
        case (idx)
            odt_pkg::IDX_NOM: begin
                rdv[odt_pkg::POS_CODE +: 3]  = s_d.nom;
                rdv[odt_pkg::POS_TDQS_EN]    = s_d.tdqs_en;
                rdv[odt_pkg::POS_X16]        = s_d.x16;
            end
            odt_pkg::IDX_WR: begin
                rdv[odt_pkg::POS_CODE +: 3]     = s_d.wr;
                rdv[odt_pkg::POS_WR_START +: 6] = s_d.wr_start;
                rdv[odt_pkg::POS_WR_LEN +: 6]   = s_d.wr_len;
            end
            odt_pkg::IDX_PARK: begin
                rdv[odt_pkg::POS_CODE +: 3] = s_d.park;
            end
            odt_pkg::IDX_LAT: begin
                rdv[odt_pkg::POS_RL +: 6]      = s_d.rl;
                rdv[odt_pkg::POS_PIN_LAT +: 6] = s_d.pin_lat;
                rdv[odt_pkg::POS_PRE2]         = s_d.pre2;
                rdv[odt_pkg::POS_CRC]          = s_d.crc;
                rdv[odt_pkg::POS_BC4]          = s_d.bc4;
            end
            odt_pkg::IDX_STAT: begin
                rdv[odt_pkg::POS_ST_SEL +: 4]  = s_q.term.sel;
                rdv[odt_pkg::POS_ST_CODE +: 3] = s_q.term.code;
                rdv[odt_pkg::POS_ST_RX]        = s_q.term.pin_rx_en;
                rdv[odt_pkg::POS_ST_SREF]      = cmd.sref;
                rdv[odt_pkg::POS_ST_RDOFF]     = in_rd;
            end
            default: begin
            end
        endcase

        // Address phase capture; unmapped reads give zero
        s_d.ap_wr  = ap_take & hwrite;
        s_d.ap_ok  = ap_take & mapped;
        s_d.ap_idx = idx;
        if (ap_take && !hwrite) begin
            s_d.hrdata = mapped ? rdv : 32'h0000_0000;
        end
        s_d.hreadyout = 1'b1;
        s_d.hresp     = 1'b0;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q           <= '0;
            s_q.nom       <= odt_pkg::RST_CODE;
            s_q.wr        <= odt_pkg::RST_CODE;
            s_q.park      <= odt_pkg::RST_CODE;
            s_q.wr_start  <= odt_pkg::RST_WR_START;
            s_q.wr_len    <= odt_pkg::RST_WR_LEN;
            s_q.rl        <= odt_pkg::RST_RL;
            s_q.pin_lat   <= odt_pkg::RST_PIN_LAT;
            s_q.hreadyout <= 1'b1;
            s_q.term.sel  <= odt_pkg::ST_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata    = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp     = s_q.hresp;
    assign term      = s_q.term;

endmodule

// ---- verification/odt_ctrl_assertions.sv ----
// Purpose: Port assertions for the termination selector
// Assumes: Sees odt_ctrl ports only
// Notes:   Window timing is judged by the bench
`timescale 1ns/1ps
module odt_ctrl_chk (
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [2:0]         hsize,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire odt_pkg::odt_cmd_t  cmd,
    input wire odt_pkg::odt_term_t term
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    chk_sref_off: assert property (
        cmd.sref |=> term.sel == odt_pkg::ST_OFF)
        else $error("termination on in self refresh");
    chk_sref_rx: assert property (
        cmd.sref |=> !term.pin_rx_en)
        else $error("pin receiver on in self refresh");
    chk_one_state: assert property (
        $onehot(term.sel))
        else $error("selection not one of four states");
    chk_off_code: assert property (
        term.sel == odt_pkg::ST_OFF |-> term.code == 3'h0)
        else $error("code not zero while off");
    chk_on_code: assert property (
        term.sel != odt_pkg::ST_OFF |-> term.code != 3'h0)
        else $error("state on with a zero field");
    chk_nom_rx: assert property (
        term.sel == odt_pkg::ST_NOM |-> term.pin_rx_en)
        else $error("nominal with receiver off");
    chk_off_lanes: assert property (
        term.sel == odt_pkg::ST_OFF |-> !(term.lo_lane || term.tdqs))
        else $error("lane terminated while off");
    chk_lane_pair: assert property (
        term.hi_lane |-> term.lo_lane && !term.tdqs)
        else $error("upper lane without lower lane");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");

    cover property (term.sel == odt_pkg::ST_WR);
    cover property (term.sel == odt_pkg::ST_NOM);
    cover property (term.sel == odt_pkg::ST_PARK);
endmodule

// ---- verification/odt_host.sv ----
// Purpose: Memory controller model driving commands and pin
// Assumes: Calls made just after a rising edge
// Notes:   Read inversion is never used, so no pairing needed
`timescale 1ns/1ps
module odt_host (
    input  wire logic         sys_clk,
    output odt_pkg::odt_cmd_t cmd
);
    initial cmd = '0;

    // Pulses last for exactly one sampling edge
    always @(posedge sys_clk) begin
        if (cmd.wr_cmd || cmd.rd_cmd) begin
            cmd.wr_cmd <= 1'b0;
            cmd.rd_cmd <= 1'b0;
        end
    end

    task automatic pulse(input logic rd);
        if (rd) cmd.rd_cmd <= 1'b1;
        else cmd.wr_cmd <= 1'b1;
    endtask

    task automatic level(input logic sref, input logic pin);
        cmd.sref <= sref;
        cmd.pin  <= pin;
    endtask
endmodule

// ---- verification/tb_dram_on_die_termination_ctrl.sv ----
// Purpose: Self-checking bench for the termination selector
// Assumes: Zero-wait slave, pin latency from the LAT register
// Notes:   Windows are checked edge by edge
`timescale 1ns/1ps
module tb_dram_on_die_termination_ctrl;
    logic               sys_clk;
    logic               rstn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic               hready;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    odt_pkg::odt_cmd_t  cmd;
    odt_pkg::odt_term_t term;
    int                 miscompares;
    int                 total_checks;
    int                 cycles;
    logic [31:0]        rd;
    localparam logic [31:0] LAT0 = 32'h0000_090b;

    assign hready = hreadyout;
    odt_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd(cmd), .term(term));
    odt_host host (.sys_clk(sys_clk), .cmd(cmd));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 800 cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic cfg(input logic [31:0] n, w, p, l);
        bus(1'b1, odt_pkg::OFF_NOM, n);
        bus(1'b1, odt_pkg::OFF_WR, w);
        bus(1'b1, odt_pkg::OFF_PARK, p);
        bus(1'b1, odt_pkg::OFF_LAT, l);
    endtask

    task automatic chk_term(input odt_pkg::odt_sel_t s, input logic [2:0] c);
        check("sel", {28'h0, term.sel}, {28'h0, s});
        check("code", {29'h0, term.code}, {29'h0, c});
        check("lane", {31'h0, term.lo_lane}, {31'h0, s != odt_pkg::ST_OFF});
    endtask

    // Pin set, then let the pin latency run out
    task automatic settle(input logic sref, input logic pin);
        @(posedge sys_clk);
        host.level(sref, pin);
        repeat (12) @(posedge sys_clk);
        #1;
    endtask

    task automatic win(input int lo, hi, last,
                       input odt_pkg::odt_sel_t si, input logic [2:0] ci,
                       input odt_pkg::odt_sel_t so, input logic [2:0] co);
        for (int k = 0; k <= last; k++) begin
            @(posedge sys_clk);
            #1;
            if (k >= lo && k < hi) chk_term(si, ci);
            else chk_term(so, co);
        end
    endtask

    task automatic s_reset;
        chk_term(odt_pkg::ST_OFF, 3'h0);
        check("rx", {31'h0, term.pin_rx_en}, 32'h0);
        bus(1'b0, odt_pkg::OFF_WR, 32'h0);
        check("wr reg", rd, 32'h0006_0700);
        bus(1'b0, odt_pkg::OFF_LAT, 32'h0);
        check("lat reg", rd, LAT0);
        bus(1'b0, 32'h0000_0014, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, odt_pkg::OFF_STAT, 32'hffff_ffff);
        bus(1'b0, odt_pkg::OFF_STAT, 32'h0);
        check("stat", rd, 32'h0000_0001);
    endtask

    task automatic s_states;
        logic [2:0] p;
        logic [2:0] n;
        for (int i = 0; i < 8; i++) begin
            p = i[0] ? 3'h5 : 3'h0;
            n = i[1] ? 3'h3 : 3'h0;
            cfg({29'h0, n}, 32'h0, {29'h0, p}, LAT0);
            settle(1'b0, i[2]);
            if (i[2] && n != 3'h0) chk_term(odt_pkg::ST_NOM, n);
            else if (p != 3'h0) chk_term(odt_pkg::ST_PARK, p);
            else chk_term(odt_pkg::ST_OFF, 3'h0);
            check("rx", {31'h0, term.pin_rx_en}, {31'h0, n != 3'h0});
        end
    endtask

    task automatic s_write;
        cfg(32'h3, 32'h0006_0702, 32'h5, LAT0);
        settle(1'b0, 1'b1);
        host.pulse(1'b0);
        win(7, 13, 15, odt_pkg::ST_WR, 3'h2,
            odt_pkg::ST_NOM, 3'h3);
        cfg(32'h3, 32'h0006_0700, 32'h5, LAT0);
        settle(1'b0, 1'b0);
        host.pulse(1'b0);
        win(0, 0, 14, odt_pkg::ST_OFF, 3'h0, odt_pkg::ST_PARK, 3'h5);
    endtask

    task automatic s_read;
        int s;
        int d;
        for (int j = 0; j < 8; j++) begin
            s = 9 - j[0];
            d = (j[2] ? 2 : 4) + 2 + j[0] + j[1];
            cfg(32'h3, 32'h0, 32'h5, LAT0 | (32'(j) << 16));
            settle(1'b0, 1'b1);
            host.pulse(1'b1);
            win(s, s + d, s + d + 1, odt_pkg::ST_OFF, 3'h0,
                odt_pkg::ST_NOM, 3'h3);
        end
    endtask

    task automatic s_pin;
        int l;
        for (int j = 0; j < 2; j++) begin
            l = 7 - j;
            cfg(32'h3, 32'h0, 32'h0, LAT0 | (32'(j) << 16));
            settle(1'b0, 1'b0);
            host.level(1'b0, 1'b1);
            win(l, 99, l + 1, odt_pkg::ST_NOM, 3'h3, odt_pkg::ST_OFF, 3'h0);
            host.level(1'b0, 1'b0);
            win(l, 99, l + 1, odt_pkg::ST_OFF, 3'h0, odt_pkg::ST_NOM, 3'h3);
        end
    endtask

    task automatic s_sref;
        cfg(32'h3, 32'h0006_0702, 32'h5, LAT0);
        settle(1'b0, 1'b1);
        host.level(1'b1, 1'b1);
        host.pulse(1'b0);
        win(0, 9, 9, odt_pkg::ST_OFF, 3'h0,
            odt_pkg::ST_OFF, 3'h0);
        check("rx", {31'h0, term.pin_rx_en}, 32'h0);
        settle(1'b0, 1'b0);
    endtask

    task automatic s_lanes;
        cfg(32'h0000_000b, 32'h0, 32'h0, LAT0);
        settle(1'b0, 1'b1);
        check("tdqs", {31'h0, term.tdqs}, 32'h1);
        check("hi", {31'h0, term.hi_lane}, 32'h0);
        bus(1'b0, odt_pkg::OFF_STAT, 32'h0);
        check("stat", rd, 32'h0000_0134);
        bus(1'b1, odt_pkg::OFF_NOM, 32'h0000_0013);
        settle(1'b0, 1'b1);
        check("tdqs", {31'h0, term.tdqs}, 32'h0);
        check("hi", {31'h0, term.hi_lane}, 32'h1);
    endtask

    // Reset in mid-run, with nominal termination on
    task automatic s_rst2;
        @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_term(odt_pkg::ST_OFF, 3'h0);
        check("hi", {31'h0, term.hi_lane}, 32'h0);
        @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        bus(1'b0, odt_pkg::OFF_NOM, 32'h0);
        check("nom reg", rd, 32'h0);
        check("rx", {31'h0, term.pin_rx_en}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cycles = 0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        s_reset();
        s_states();
        s_write();
        s_read();
        s_pin();
        s_sref();
        s_lanes();
        s_rst2();
        test_done();
    end
endmodule

bind odt_ctrl odt_ctrl_chk u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmd(cmd), .term(term));
